//--- rtl/grp_xfer.sv
// grouped port block transfer engine with apb register access
module grp_xfer
    import grp_xfer_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [31:0] port_in,
    output logic      [31:0] port_out,
    output logic      [3:0]  port_oe,
    input  wire logic        hs_req,
    output logic             hs_ack,
    input  wire logic        external_tick_input_one,
    input  wire logic        external_tick_input_two,
    input  wire logic        external_tick_input_three,
    input  wire logic        external_tick_input_four,
    input  wire logic        external_tick_input_five,
    input  wire logic        dma_enhanced
);
    timeunit 1ns;
    timeprecision 1ns;
    import grp_xfer_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [2:0]  size_reg, size_next;
    logic [1:0]  sel_reg, sel_next;
    logic        dir_reg, dir_next;
    logic [31:0] count_reg, count_next;
    logic [15:0] interval_reg, interval_next;
    logic [3:0]  tb_reg, tb_next;
    xfer_state_t state_reg, state_next;
    logic [15:0] ivl_cnt_reg, ivl_cnt_next;
    logic        done_reg, done_next;
    logic        rdy_reg, rdy_next;
    logic        err_reg, err_next;
    logic [31:0] wdata_reg, wdata_next;
    logic        wfull_reg, wfull_next;
    logic [31:0] rdata_reg, rdata_next;
    logic        rval_reg, rval_next;
    logic [31:0] pout_reg, pout_next;
    logic [3:0]  oe_reg, oe_next;
    logic [31:0] single_reg, single_next;
    logic        ack_reg, ack_next;
    logic        req_d_reg;
    logic [4:0]  pre_reg, pre_next;
    logic [3:0]  dec_reg [4], dec_next [4];
    logic [4:0]  ext_d_reg;
    logic [31:0] prdata_reg, prdata_next;
    logic        pslverr_reg, pslverr_next;
    logic        pready_reg, pready_next;

    logic [3:0]  mask;
    logic [4:0]  int_tick;
    logic [4:0]  ext_in;
    logic        tick;
    logic        go;
    logic        bpw;
    logic        acc;
    logic [31:0] lane_out;
    logic [31:0] lane_in;
    logic [31:0] per_bytes;

    assign ext_in = {external_tick_input_five, external_tick_input_four,
                     external_tick_input_three, external_tick_input_two,
                     external_tick_input_one};

    // ----------------------------------------------------------------
    // port membership from size and selector
    // ----------------------------------------------------------------
    always_comb
    begin
        case (size_reg)
            size_one:  mask = 4'h1 << sel_reg;
            size_two:  mask = (sel_reg == 2'd2) ? 4'hC : 4'h3;
            size_four: mask = 4'hF;
            default:   mask = 4'h0;
        endcase
    end

    // ----------------------------------------------------------------
    // lane mapping: port p occupies port_in/out bits [8p+7:8p]
    // ----------------------------------------------------------------
    always_comb
    begin
        lane_out = pout_reg;
        lane_in  = 32'h0000_0000;
        per_bytes = 32'h0000_0001;
        case (size_reg)
            size_one:
            begin
                lane_out[8*sel_reg +: 8] = wdata_reg[7:0];
                lane_in[7:0] = port_in[8*sel_reg +: 8];
            end
            size_two:
            begin
                per_bytes = 32'h0000_0002;
                lane_out[8*sel_reg +: 16] = {wdata_reg[7:0], wdata_reg[15:8]};
                lane_in[15:0] = {port_in[8*sel_reg +: 8], port_in[8*sel_reg+8 +: 8]};
            end
            size_four:
            begin
                per_bytes = 32'h0000_0004;
                lane_out = {wdata_reg[7:0], wdata_reg[15:8],
                            wdata_reg[23:16], wdata_reg[31:24]};
                lane_in = {port_in[7:0], port_in[15:8], port_in[23:16], port_in[31:24]};
            end
            default: ;
        endcase
    end

    // ----------------------------------------------------------------
    // timebase: 1 MHz prescaler and decade chain
    // ----------------------------------------------------------------
    always_comb
    begin
        pre_next = (pre_reg == 5'(tick_div - 1)) ? 5'd0 : pre_reg + 5'd1;
        int_tick[0] = (pre_reg == 5'(tick_div - 1));
        for (int i = 0; i < 4; i++)
        begin
            dec_next[i] = dec_reg[i];
            if (int_tick[i])
                dec_next[i] = (dec_reg[i] == 4'(decade - 1)) ? 4'd0 : dec_reg[i] + 4'd1;
            int_tick[i+1] = int_tick[i] && (dec_reg[i] == 4'(decade - 1));
        end
        if (tb_reg >= tb_int_first && tb_reg <= tb_int_last)
            tick = int_tick[3'(tb_reg - tb_int_first)];
        else if (tb_reg >= tb_ext_first && tb_reg <= tb_ext_last)
            tick = ext_in[3'(tb_reg - tb_ext_first)] && !ext_d_reg[3'(tb_reg - tb_ext_first)];
        else
            tick = 1'b0;
    end

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    assign acc = psel && penable && !pready_reg;
    assign bpw = acc && pwrite;

    // ----------------------------------------------------------------
    // transfer engine and registers
    // ----------------------------------------------------------------
    always_comb
    begin
        size_next = size_reg;
        sel_next = sel_reg;
        dir_next = dir_reg;
        count_next = count_reg;
        interval_next = interval_reg;
        tb_next = tb_reg;
        state_next = state_reg;
        ivl_cnt_next = ivl_cnt_reg;
        done_next = done_reg;
        rdy_next = rdy_reg;
        err_next = err_reg;
        wdata_next = wdata_reg;
        wfull_next = wfull_reg;
        rdata_next = rdata_reg;
        rval_next = rval_reg;
        pout_next = pout_reg;
        oe_next = oe_reg;
        single_next = single_reg;
        ack_next = 1'b0;
        prdata_next = 32'h0000_0000;
        pslverr_next = 1'b0;
        pready_next = acc;
        go = 1'b0;

        // pattern move condition
        if (state_reg == st_move)
        begin
            if (interval_reg == 16'h0000)
                go = hs_req && !req_d_reg;
            else if (tick)
            begin
                if (ivl_cnt_reg <= 16'h0001)
                    go = 1'b1;
                ivl_cnt_next = (ivl_cnt_reg <= 16'h0001) ? interval_reg
                               : ivl_cnt_reg - 16'h0001;
            end
            if (dir_reg == dir_out && !wfull_reg)
                go = 1'b0;
            if (dir_reg == dir_in && rval_reg)
                go = 1'b0;
        end

        if (go)
        begin
            ack_next = 1'b1;
            rdy_next = 1'b1;
            if (dir_reg == dir_out)
            begin
                pout_next = lane_out;
                wfull_next = 1'b0;
            end
            else
            begin
                rdata_next = lane_in;
                rval_next = 1'b1;
            end
            if (count_reg <= per_bytes)
            begin
                count_next = 32'h0000_0000;
                state_next = st_idle;
                done_next = 1'b1;
            end
            else
                count_next = count_reg - per_bytes;
        end

        // single-port output writes only reach unassigned ports
        for (int p = 0; p < 4; p++)
            if (!mask[p])
                pout_next[8*p +: 8] = single_reg[8*p +: 8];

        if (bpw)
        begin
            case (paddr)
                cfg_off:
                    if (state_reg == st_idle)
                    begin
                        if (pwdata[cfg_size_lsb +: 3] == size_none)
                        begin
                            size_next = size_none;
                            rdy_next = 1'b0;
                            wfull_next = 1'b0;
                            rval_next = 1'b0;
                            dir_next = pwdata[cfg_dir_bit];
                        end
                        else if ((pwdata[cfg_size_lsb +: 3] == size_one) ||
                                 (pwdata[cfg_size_lsb +: 3] == size_two &&
                                  !pwdata[cfg_sel_lsb] ) ||
                                 (pwdata[cfg_size_lsb +: 3] == size_four &&
                                  pwdata[cfg_sel_lsb +: 2] == 2'd0))
                        begin
                            size_next = pwdata[cfg_size_lsb +: 3];
                            sel_next = pwdata[cfg_sel_lsb +: 2];
                            dir_next = pwdata[cfg_dir_bit];
                            rdy_next = 1'b0;
                        end
                        else
                            pslverr_next = 1'b1;
                    end
                    else
                        pslverr_next = 1'b1;
                count_off: count_next = pwdata;
                pace_off:
                begin
                    interval_next = pwdata[15:0];
                    tb_next = pwdata[pace_tb_lsb +: 4];
                end
                wdata_off:
                begin
                    wdata_next = pwdata;
                    wfull_next = 1'b1;
                    if (!go)
                        rdy_next = 1'b0;
                end
                port_wr_off: single_next = pwdata;
                launch_off:
                begin
                    if (size_reg == size_none)
                        err_next = 1'b1;
                    else if (pwdata[launch_dir_bit] != dir_reg)
                        err_next = 1'b1;
                    else if (interval_reg == 16'h0001)
                        err_next = 1'b1;
                    else if (interval_reg != 16'h0000 && !(tb_reg >= tb_int_first &&
                             tb_reg <= tb_ext_last))
                        err_next = 1'b1;
                    else if (pwdata[launch_dma_bit] && count_reg > dma_count_max)
                        err_next = 1'b1;
                    else if ((pwdata[launch_dma_bit] || interval_reg != 16'h0000) &&
                             !((sel_reg == 2'd0) ||
                               (sel_reg == 2'd2 && size_reg != size_four &&
                                dma_enhanced)))
                        err_next = 1'b1;
                    else if (count_reg == 32'h0000_0000)
                        err_next = 1'b1;
                    else
                    begin
                        err_next = 1'b0;
                        done_next = 1'b0;
                        state_next = st_move;
                        ivl_cnt_next = interval_reg;
                        oe_next = (dir_reg == dir_out) ? mask : 4'h0;
                    end
                end
                default: pslverr_next = !(paddr == status_off || paddr == rdata_off ||
                                          paddr == port_rd_off);
            endcase
        end
        else if (acc)
        begin
            case (paddr)
                cfg_off:     prdata_next = {23'h0, dir_reg, 2'h0, sel_reg, 1'b0, size_reg};
                count_off:   prdata_next = count_reg;
                pace_off:    prdata_next = {12'h0, tb_reg, interval_reg};
                status_off:  prdata_next = {27'h0, rval_reg, wfull_reg, err_reg,
                                            rdy_reg && size_reg != size_none, done_reg};
                wdata_off:   prdata_next = wdata_reg;
                rdata_off:
                begin
                    prdata_next = rdata_reg;
                    if (!go)
                    begin
                        rval_next = 1'b0;
                        rdy_next = 1'b0;
                    end
                end
                port_rd_off:
                    for (int p = 0; p < 4; p++)
                        prdata_next[8*p +: 8] = mask[p] ? 8'h00 : port_in[8*p +: 8];
                launch_off:  prdata_next = 32'h0000_0000;
                port_wr_off: prdata_next = single_reg;
                default:     pslverr_next = 1'b1;
            endcase
        end

        if (size_next == size_none)
        begin
            oe_next = 4'h0;
            state_next = st_idle;
        end
        else if (state_next == st_idle)
            oe_next = (dir_next == dir_out) ? mask : 4'h0;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            size_reg <= size_none;
            sel_reg <= 2'd0;
            dir_reg <= dir_in;
            count_reg <= 32'h0000_0000;
            interval_reg <= 16'h0000;
            tb_reg <= 4'h0;
            state_reg <= st_idle;
            ivl_cnt_reg <= 16'h0000;
            done_reg <= 1'b1;
            rdy_reg <= 1'b0;
            err_reg <= 1'b0;
            wdata_reg <= 32'h0000_0000;
            wfull_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rval_reg <= 1'b0;
            pout_reg <= 32'h0000_0000;
            oe_reg <= 4'h0;
            single_reg <= 32'h0000_0000;
            ack_reg <= 1'b0;
            req_d_reg <= 1'b0;
            pre_reg <= 5'd0;
            for (int i = 0; i < 4; i++)
                dec_reg[i] <= 4'd0;
            ext_d_reg <= 5'd0;
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
            pready_reg <= 1'b0;
        end
        else
        begin
            size_reg <= size_next;
            sel_reg <= sel_next;
            dir_reg <= dir_next;
            count_reg <= count_next;
            interval_reg <= interval_next;
            tb_reg <= tb_next;
            state_reg <= state_next;
            ivl_cnt_reg <= ivl_cnt_next;
            done_reg <= done_next;
            rdy_reg <= rdy_next;
            err_reg <= err_next;
            wdata_reg <= wdata_next;
            wfull_reg <= wfull_next;
            rdata_reg <= rdata_next;
            rval_reg <= rval_next;
            pout_reg <= pout_next;
            oe_reg <= oe_next;
            single_reg <= single_next;
            ack_reg <= ack_next;
            req_d_reg <= hs_req;
            pre_reg <= pre_next;
            for (int i = 0; i < 4; i++)
                dec_reg[i] <= dec_next[i];
            ext_d_reg <= ext_in;
            prdata_reg <= prdata_next;
            pslverr_reg <= pslverr_next;
            pready_reg <= pready_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign port_out = pout_reg;
    assign port_oe = oe_reg;
    assign hs_ack = ack_reg;

endmodule : grp_xfer

//--- rtl/grp_xfer_pkg.sv
// constants, register map and types for the grouped port block transfer engine
package grp_xfer_pkg;
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] cfg_off        = 8'h00;
    localparam logic [7:0] launch_off     = 8'h04;
    localparam logic [7:0] count_off      = 8'h08;
    localparam logic [7:0] pace_off       = 8'h0C;
    localparam logic [7:0] status_off     = 8'h10;
    localparam logic [7:0] wdata_off      = 8'h14;
    localparam logic [7:0] rdata_off      = 8'h18;
    localparam logic [7:0] port_wr_off    = 8'h1C;
    localparam logic [7:0] port_rd_off    = 8'h20;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int cfg_size_lsb  = 0;
    localparam int cfg_sel_lsb   = 4;
    localparam int cfg_dir_bit   = 8;
    localparam int launch_dir_bit = 0;
    localparam int launch_dma_bit = 1;
    localparam int launch_dmax_bit = 2;
    localparam int pace_tb_lsb   = 16;
    localparam int st_done_bit   = 0;
    localparam int st_rdy_bit    = 1;
    localparam int st_err_bit    = 2;
    localparam int st_wreq_bit   = 3;
    localparam int st_rval_bit   = 4;

    // ----------------------------------------------------------------
    // codes and limits
    // ----------------------------------------------------------------
    localparam logic [2:0]  size_none = 3'h0;
    localparam logic [2:0]  size_one  = 3'h1;
    localparam logic [2:0]  size_two  = 3'h2;
    localparam logic [2:0]  size_four = 3'h4;
    localparam logic        dir_in    = 1'b0;
    localparam logic        dir_out   = 1'b1;
    localparam logic [15:0] interval_min = 16'h0002;
    localparam logic [3:0]  tb_int_first = 4'h1;
    localparam logic [3:0]  tb_int_last  = 4'h5;
    localparam logic [3:0]  tb_ext_first = 4'h6;
    localparam logic [3:0]  tb_ext_last  = 4'hA;
    localparam logic [31:0] dma_count_max = 32'h00FF_FFFF;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int clk_hz        = 25_000_000;
    localparam int tick_1mhz_hz  = 1_000_000;
    localparam int tick_div      = clk_hz / tick_1mhz_hz;
    localparam int decade        = 10;

    typedef enum logic [1:0] {st_idle, st_wait, st_move} xfer_state_t;

endpackage : grp_xfer_pkg

//--- verification/grp_xfer_checker.sv
// assertion checker for the grouped port transfer engine
module grp_xfer_checker (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] port_out,
    input wire logic [3:0]  port_oe,
    input wire logic        hs_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    import grp_xfer_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    apb_answer_a: assert property (psel && penable && !pready |=> pready)
        else $error("access not answered");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    oe_group_a: assert property (port_oe inside {0, 1, 2, 4, 8, 3, 12, 15})
        else $error("illegal port set driven");
    out_cause_a: assert property (port_out != $past(port_out) |->
        hs_ack || $past(psel && penable && pwrite))
        else $error("port_out moved without cause");
    oe_cause_a: assert property (port_oe != $past(port_oe) |->
        $past(psel && penable && pwrite && paddr == cfg_off))
        else $error("port_oe moved without config");
    ack_pulse_a: assert property (hs_ack |=> !hs_ack)
        else $error("hs_ack held");
    reset_idle_a: assert property ($fell(rst) |-> port_oe == 4'h0 && port_out == 32'h0000_0000)
        else $error("ports driven after reset");
endmodule : grp_xfer_checker

//--- verification/hs_partner.sv
// model of the external equipment on the handshake lines
module hs_partner (
    input  wire logic        ref_clk,
    input  wire logic        fire,
    input  wire logic        slow,
    input  wire logic [31:0] data,
    input  wire logic        hs_ack,
    output logic             hs_req,
    output logic      [31:0] port_in
);
    timeunit 1ns;
    timeprecision 1ns;
    int wait_n = 0;
    initial
    begin
        hs_req = 1'b0;
        port_in = 32'h0000_0000;
        forever
        begin
            @(posedge ref_clk);
            if (fire)
                wait_n <= slow ? 6 : 1;
            else if (wait_n > 0)
                wait_n <= wait_n - 1;
            hs_req <= (wait_n == 1 && !fire) || (hs_req && !hs_ack);
            port_in <= ((wait_n == 1 && !fire) || hs_req) ? data : ~port_in;
        end
    end
endmodule : hs_partner

//--- verification/tb.sv
// self-checking testbench for the grouped port transfer engine
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import grp_xfer_pkg::*;
    logic        ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic        fire = 0, slow = 0, dma_enh = 0, pready, pslverr, hs_req, hs_ack, e;
    logic [7:0]  paddr = 8'h00;
    logic [4:0]  ext = 5'h00;
    logic [3:0]  port_oe;
    logic [31:0] pwdata = 32'h0000_0000, pdata = 32'h0000_0000, prdata, r, x;
    logic [31:0] port_in, port_out, q[$];
    int          errors = 0, total_checks = 0, seed = 66;
    time         t0;
    initial
    begin
        forever #20 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) ext <= ext + 5'h01;
    grp_xfer u_grp_xfer (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port_in(port_in), .port_out(port_out), .port_oe(port_oe),
        .hs_req(hs_req), .hs_ack(hs_ack), .external_tick_input_one(ext[0]),
        .external_tick_input_two(ext[1]), .external_tick_input_three(ext[2]),
        .external_tick_input_four(ext[3]), .external_tick_input_five(ext[4]),
        .dma_enhanced(dma_enh));
    hs_partner u_hs_partner (.ref_clk(ref_clk), .fire(fire), .slow(slow), .data(pdata),
        .hs_ack(hs_ack), .hs_req(hs_req), .port_in(port_in));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic fail(input string m);
        errors++;
        $display("CHECK FAILED t=%0t %s", $time, m);
    endtask : fail
    task automatic chk(input logic [31:0] g, input logic [31:0] w);
        total_checks++;
        if (g !== w) fail($sformatf("got %h expected %h", g, w));
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1 && ++n < 16);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
        if (n >= 16) fail("no apb answer");
    endtask : apb
    task automatic wack();
        int n = 0;
        do @(posedge ref_clk); while (hs_ack !== 1'b1 && ++n < 2000);
        if (n >= 2000) fail("no pattern moved");
    endtask : wack
    task automatic hand(input logic s);
        slow <= s;
        fire <= 1'b1;
        @(posedge ref_clk);
        fire <= 1'b0;
        wack();
    endtask : hand
    function automatic logic [31:0] lanes(input logic [31:0] p, input int sz, input int sel);
        logic [31:0] v = 32'h0000_0000;
        for (int i = 0; i < sz; i++) v[8*(sel+i) +: 8] = p[8*(sz-1-i) +: 8];
        return v;
    endfunction : lanes
    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : summarize
    initial
    begin
        #2_000_000;
        fail("watchdog expired");
        summarize();
    end
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial
    begin
        logic [31:0] bad[4] = '{32'h0000_0003, 32'h0000_0012, 32'h0000_0024, 32'h0000_0005};
        logic [31:0] pace[7] = '{32'h0001_0010, 32'h0002_0002, 32'h0006_0010,
            32'h0007_0010, 32'h0008_0010, 32'h0009_0008, 32'h000A_0004};
        int gap[7] = '{400, 500, 32, 64, 128, 128, 128};
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        dma_enh <= 1'($random(seed));
        @(posedge ref_clk);
        apb(0, status_off, 0);
        chk(r & 32'h0000_0005, 32'h0000_0001);
        apb(0, cfg_off, 0);
        chk(r, 0);
        apb(1, count_off, 4);
        apb(1, launch_off, 0);
        apb(0, status_off, 0);
        chk(r[2], 1);
        foreach (bad[i])
        begin
            apb(1, cfg_off, bad[i]);
            chk(e, 1);
        end
        apb(0, 8'h30, 0);
        chk(e, 1);
        // four-port output group paced by the handshake
        apb(1, cfg_off, 32'h0000_0104);
        chk(port_oe, 4'hF);
        apb(1, pace_off, 32'h000F_0000);
        apb(1, count_off, 8);
        apb(1, launch_off, 0);
        apb(0, status_off, 0);
        chk(r[2], 1);
        apb(1, launch_off, 1);
        apb(0, status_off, 0);
        chk(r & 32'h0000_0005, 0);
        for (int k = 0; k < 2; k++)
        begin
            q.push_back($random(seed));
            apb(1, wdata_off, q[$]);
            hand(k[0]);
            x = lanes(q.pop_front(), 4, 0);
            chk(port_out, x);
            apb(0, status_off, 0);
            chk(r[3:1], 3'b001);
        end
        apb(1, port_wr_off, 32'hFFFF_FFFF);
        chk(port_out, x);
        apb(0, status_off, 0);
        chk(r[0], 1);
        // two-port input group on the upper ports
        apb(1, cfg_off, 32'h0000_0022);
        apb(1, pace_off, 0);
        apb(1, count_off, 4);
        apb(1, launch_off, 0);
        for (int k = 0; k < 2; k++)
        begin
            x = $random(seed);
            pdata <= x;
            hand(!k[0]);
            apb(0, status_off, 0);
            chk(r[4:1], 4'b1001);
            apb(0, rdata_off, 0);
            chk(r, {16'h0000, x[23:16], x[31:24]});
        end
        apb(0, status_off, 0);
        chk(r[0], 1);
        apb(1, cfg_off, 0);
        chk(port_oe, 0);
        apb(0, status_off, 0);
        chk(r[1], 0);
        // one-port output group paced by the interval counter
        apb(1, cfg_off, 32'h0000_0101);
        apb(1, count_off, 32'h0100_0000);
        apb(1, launch_off, 3);
        apb(0, status_off, 0);
        chk(r[2], 1);
        foreach (pace[i])
        begin
            apb(1, pace_off, pace[i]);
            apb(1, count_off, 2);
            apb(1, wdata_off, $random(seed));
            apb(1, launch_off, 1);
            wack();
            t0 = $time;
            x = $random(seed);
            apb(1, wdata_off, x);
            wack();
            chk(($time - t0) / 40, gap[i]);
            chk(port_out[7:0], x[7:0]);
        end
        apb(1, count_off, 1);
        apb(1, pace_off, 32'h0001_0001);
        apb(1, launch_off, 1);
        apb(0, status_off, 0);
        chk(r[2], 1);
        summarize();
    end
endmodule : tb
bind grp_xfer grp_xfer_checker u_grp_xfer_checker (.ref_clk(ref_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
    .pslverr(pslverr), .port_out(port_out), .port_oe(port_oe), .hs_ack(hs_ack));
